// file: inc/eims_pkg.sv
// eims_pkg: constants for the event interrupt mode select block.
// assumes a 32-bit classic wishbone slave on one 100 MHz clock.
package eims_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned REG_W = 8;
   localparam int unsigned EV_N = 24;
   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_MODE1 = 12'h020;
   localparam logic [ADDR_W-1:0] IDX_MODE2 = 12'h021;
   localparam logic [ADDR_W-1:0] IDX_MODE3 = 12'h022;
   localparam logic [ADDR_W-1:0] IDX_STAT1 = 12'h030;
   localparam logic [ADDR_W-1:0] IDX_STAT2 = 12'h031;
   localparam logic [ADDR_W-1:0] IDX_STAT3 = 12'h032;
   localparam logic [ADDR_W-1:0] IDX_MASK1 = 12'h034;
   localparam logic [ADDR_W-1:0] IDX_MASK2 = 12'h035;
   localparam logic [ADDR_W-1:0] IDX_MASK3 = 12'h036;
   localparam logic [REG_W-1:0] MODE1_VALID = 8'h05;
   localparam logic [REG_W-1:0] MODE2_VALID = 8'hAF;
   localparam logic [REG_W-1:0] MODE3_VALID = 8'hAC;
   localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
   localparam logic [REG_W-1:0] MASK_RESET = 8'hFF;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// file: design/eims_sync.sv
// eims_sync: two-flop synchroniser for a vector of level inputs.
// assumes inputs come from another clock domain or from pins.
`timescale 1ns/1ns
`default_nettype none
module eims_sync #(
   parameter int unsigned WIDTH = 24
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } eims_sync_s;
   eims_sync_s st_q;
   eims_sync_s st_d;
   always_comb begin
      st_d.meta = async_i;
      // only the second stage reads the first
      st_d.stable = st_q.meta;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign sync_o = st_q.stable;
endmodule
`default_nettype wire

// file: design/eims_event_cell.sv
// eims_event_cell: one event; latch on rising edge in latch mode, else live level.
// assumes event level is already synchronous to clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
module eims_event_cell (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic level_i,
   input wire logic latch_mode_i,
   input wire logic clear_i,
   output logic status_o,
   output logic pending_o
);
   typedef struct packed {
      logic prev;
      logic flag;
   } eims_cell_s;
   eims_cell_s st_q;
   eims_cell_s st_d;
   logic rise;
   always_comb begin
      rise = level_i & ~st_q.prev;
      st_d.prev = level_i;
      st_d.flag = st_q.flag;
      if (!latch_mode_i) begin
         st_d.flag = 1'b0;
      end else if (rise) begin
         st_d.flag = 1'b1; // set wins over a clear in the same cycle
      end else if (clear_i) begin
         st_d.flag = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign status_o = latch_mode_i ? st_q.flag : level_i;
   assign pending_o = st_q.flag;
   a_live_no_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !latch_mode_i |=> !st_q.flag)
      else $error("flag held while in live mode");
   a_rise_latches: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (latch_mode_i && level_i && !st_q.prev) |=> st_q.flag)
      else $error("rising event not latched");
   a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.flag && latch_mode_i && !clear_i) |=> st_q.flag)
      else $error("latched flag dropped without clear");
endmodule
`default_nettype wire

// file: design/eims_top.sv
// eims_top: per-event interrupt mode select with wishbone register access.
// assumes event inputs are asynchronous levels; classic wishbone master.
`timescale 1ns/1ns
`default_nettype none
module eims_top (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [13:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic pattern_check_error_ch0_i,
   input wire logic pattern_check_error_ch1_i,
   input wire logic power_detect_error_ch0_i,
   input wire logic power_detect_error_ch1_i,
   input wire logic blanking_finished_ch0_i,
   input wire logic blanking_finished_ch1_i,
   input wire logic alignment_locked_ch0_i,
   input wire logic alignment_locked_ch1_i,
   input wire logic alignment_rotated_ch0_i,
   input wire logic alignment_rotated_ch1_i,
   input wire logic outside_window_ch0_i,
   input wire logic alignment_tripped_ch0_i,
   output logic irq_n_o,
   output logic irq_o
);
   localparam int unsigned W = eims_pkg::REG_W;
   localparam int unsigned N = eims_pkg::EV_N;
   typedef struct packed {
      logic [N-1:0] mode;
      logic [N-1:0] mask;
      logic [31:0] rdata;
      logic ack;
      logic irq_n;
      logic irq;
   } eims_top_s;
   eims_top_s st_q;
   eims_top_s st_d;
   logic [N-1:0] ev_raw;
   logic [N-1:0] ev_sync;
   logic [N-1:0] status;
   logic [N-1:0] pending;
   logic [N-1:0] clr;
   logic [N-1:0] valid;
   localparam int unsigned ADDR_W_L = eims_pkg::ADDR_W;
   logic [ADDR_W_L-1:0] idx;
   logic req;
   logic wr;
   logic [W-1:0] wbyte;
   // bit vector: [7:0] mode reg 1, [15:8] mode reg 2, [23:16] mode reg 3
   always_comb begin
      ev_raw = '0;
      ev_raw[2] = pattern_check_error_ch1_i;
      ev_raw[0] = pattern_check_error_ch0_i;
      ev_raw[15] = power_detect_error_ch0_i;
      ev_raw[13] = blanking_finished_ch0_i;
      ev_raw[11] = alignment_locked_ch0_i;
      ev_raw[10] = alignment_rotated_ch0_i;
      ev_raw[9] = outside_window_ch0_i;
      ev_raw[8] = alignment_tripped_ch0_i;
      ev_raw[23] = power_detect_error_ch1_i;
      ev_raw[21] = blanking_finished_ch1_i;
      ev_raw[19] = alignment_locked_ch1_i;
      ev_raw[18] = alignment_rotated_ch1_i;
   end
   assign valid = {eims_pkg::MODE3_VALID, eims_pkg::MODE2_VALID, eims_pkg::MODE1_VALID};
   eims_sync #(
      .WIDTH(N)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(ev_raw),
      .sync_o(ev_sync)
   );
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ev
         eims_event_cell u_cell (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .level_i(ev_sync[g] & valid[g]),
            .latch_mode_i(st_q.mode[g]),
            .clear_i(clr[g]),
            .status_o(status[g]),
            .pending_o(pending[g])
         );
      end
   endgenerate
   assign idx = wb_adr_i[13:2];
   // answer one cycle after the request; the ack gap keeps one access per request
   assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[W-1:0];
   always_comb begin
      clr = '0;
      if (wr) begin
         unique case (idx)
            eims_pkg::IDX_STAT1: clr[7:0] = wbyte;
            eims_pkg::IDX_STAT2: clr[15:8] = wbyte;
            eims_pkg::IDX_STAT3: clr[23:16] = wbyte;
            default: clr = '0;
         endcase
      end
   end
   always_comb begin
      st_d = st_q;
      st_d.ack = req;
      st_d.rdata = eims_pkg::UNMAPPED_DATA;
      if (wr) begin
         unique case (idx)
            eims_pkg::IDX_MODE1: st_d.mode[7:0] = wbyte & eims_pkg::MODE1_VALID;
            eims_pkg::IDX_MODE2: st_d.mode[15:8] = wbyte & eims_pkg::MODE2_VALID;
            eims_pkg::IDX_MODE3: st_d.mode[23:16] = wbyte & eims_pkg::MODE3_VALID;
            eims_pkg::IDX_MASK1: st_d.mask[7:0] = wbyte;
            eims_pkg::IDX_MASK2: st_d.mask[15:8] = wbyte;
            eims_pkg::IDX_MASK3: st_d.mask[23:16] = wbyte;
            default: st_d.mode = st_q.mode;
         endcase
      end
      if (req && !wb_we_i) begin
         unique case (idx)
            eims_pkg::IDX_MODE1: st_d.rdata = {24'h00_0000, st_q.mode[7:0]};
            eims_pkg::IDX_MODE2: st_d.rdata = {24'h00_0000, st_q.mode[15:8]};
            eims_pkg::IDX_MODE3: st_d.rdata = {24'h00_0000, st_q.mode[23:16]};
            eims_pkg::IDX_STAT1: st_d.rdata = {24'h00_0000, status[7:0]};
            eims_pkg::IDX_STAT2: st_d.rdata = {24'h00_0000, status[15:8]};
            eims_pkg::IDX_STAT3: st_d.rdata = {24'h00_0000, status[23:16]};
            eims_pkg::IDX_MASK1: st_d.rdata = {24'h00_0000, st_q.mask[7:0]};
            eims_pkg::IDX_MASK2: st_d.rdata = {24'h00_0000, st_q.mask[15:8]};
            eims_pkg::IDX_MASK3: st_d.rdata = {24'h00_0000, st_q.mask[23:16]};
            default: st_d.rdata = eims_pkg::UNMAPPED_DATA;
         endcase
      end
      // only latched flags can interrupt; live-mode events never do
      st_d.irq_n = ~|pending;
      st_d.irq = |(pending & st_q.mask);
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q.mode <= {eims_pkg::MODE_RESET, eims_pkg::MODE_RESET, eims_pkg::MODE_RESET};
         st_q.mask <= {eims_pkg::MASK_RESET, eims_pkg::MASK_RESET, eims_pkg::MASK_RESET};
         st_q.rdata <= eims_pkg::UNMAPPED_DATA;
         st_q.ack <= 1'b0;
         st_q.irq_n <= 1'b1;
         st_q.irq <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end
   assign wb_dat_o = st_q.rdata;
   assign wb_ack_o = st_q.ack;
   assign irq_n_o = st_q.irq_n;
   assign irq_o = st_q.irq;
   a_irq_follows_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (|pending) |=> !irq_n_o)
      else $error("irq line not low with pending flag");
   a_irq_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (pending == '0) |=> irq_n_o)
      else $error("irq line low without pending flag");
   a_live_no_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode == '0 && pending == '0) |=> ##1 irq_n_o)
      else $error("irq asserted in live mode");
   a_ch1_pattern: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[2] && $rose(ev_sync[2])) |=> ##1 !irq_n_o)
      else $error("ch1 pattern error did not interrupt");
   a_ch0_power: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[15] && $rose(ev_sync[15])) |=> pending[15])
      else $error("ch0 power error not latched");
   a_wb_ack_once: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_timing: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_mode_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr && idx == eims_pkg::IDX_MODE1) |=> st_q.mode[0] == $past(wb_dat_i[0]))
      else $error("mode bit not written");

   // every valid mode bit latches its own event
   a_ch1_pattern_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[2] && $rose(ev_sync[2]))
      |=> pending[2])
      else $error("ch1 pattern error not latched");
   a_ch0_pattern_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[0] && $rose(ev_sync[0]))
      |=> pending[0])
      else $error("ch0 pattern error not latched");
   a_ch0_blank_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[13] && $rose(ev_sync[13]))
      |=> pending[13])
      else $error("ch0 blanking finished not latched");
   a_ch0_lock_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[11] && $rose(ev_sync[11]))
      |=> pending[11])
      else $error("ch0 alignment locked not latched");
   a_ch0_rotate_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[10] && $rose(ev_sync[10]))
      |=> pending[10])
      else $error("ch0 alignment rotated not latched");
   a_ch0_window_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[9] && $rose(ev_sync[9]))
      |=> pending[9])
      else $error("ch0 outside window not latched");
   a_ch0_trip_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[8] && $rose(ev_sync[8]))
      |=> pending[8])
      else $error("ch0 alignment tripped not latched");
   a_ch1_power_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[23] && $rose(ev_sync[23]))
      |=> pending[23])
      else $error("ch1 power error not latched");
   a_ch1_blank_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[21] && $rose(ev_sync[21]))
      |=> pending[21])
      else $error("ch1 blanking finished not latched");
   a_ch1_lock_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[19] && $rose(ev_sync[19]))
      |=> pending[19])
      else $error("ch1 alignment locked not latched");
   a_ch1_rotate_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_q.mode[18] && $rose(ev_sync[18]))
      |=> pending[18])
      else $error("ch1 alignment rotated not latched");

   // live mode: status follows the synchronised level, two cycles behind the pin
   a_live_status_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && !wb_we_i && idx == eims_pkg::IDX_STAT2 && !st_q.mode[15])
      |=> wb_dat_o[7] == $past(ev_sync[15]))
      else $error("live status not the current level");
   a_live_drops_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !st_q.mode[15]
      |=> !pending[15])
      else $error("flag kept in live mode");

   // reserved mode and flag bits never hold state; every mask bit is writable
   a_reserved_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr && idx == eims_pkg::IDX_MODE2)
      |=> (st_q.mode & ~valid) == '0)
      else $error("reserved mode bit written");
   a_reserved_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $changed(ev_sync)
      |=> (pending & ~valid) == '0)
      else $error("reserved flag set");

   // clear by writing one; a rising edge in the same cycle still wins
   a_clear_drops: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr && idx == eims_pkg::IDX_STAT1 && wbyte[0] && !$rose(ev_sync[0]))
      |=> !pending[0])
      else $error("flag not cleared by write of one");

   // interrupt outputs
   a_irq_unmasked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (|(pending & st_q.mask))
      |=> irq_o)
      else $error("unmasked flag without irq");
   a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ((pending & st_q.mask) == '0)
      |=> !irq_o)
      else $error("irq without unmasked flag");
   a_irq_pair: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      irq_o
      |-> !irq_n_o)
      else $error("irq high while irq line released");

   // register bus
   a_ack_after_req: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wb_ack_o
      |-> $past(wb_stb_i))
      else $error("ack without request");
   a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !wb_ack_o
      |-> wb_dat_o == eims_pkg::UNMAPPED_DATA)
      else $error("read data outside ack");
   a_rdata_upper: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      wb_ack_o
      |-> wb_dat_o[31:W] == '0)
      else $error("upper read bits not zero");
   a_mode_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && !wb_we_i && idx == eims_pkg::IDX_MODE2)
      |=> wb_dat_o[W-1:0] == $past(st_q.mode[15:8]))
      else $error("mode read data wrong");
   a_stat_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && !wb_we_i && idx == eims_pkg::IDX_STAT2)
      |=> wb_dat_o[W-1:0] == $past(status[15:8]))
      else $error("status read data wrong");
   a_mask_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && !wb_we_i && idx == eims_pkg::IDX_MASK3)
      |=> wb_dat_o[W-1:0] == $past(st_q.mask[23:16]))
      else $error("mask read data wrong");
   a_mask_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr && idx == eims_pkg::IDX_MASK1)
      |=> st_q.mask[7:0] == $past(wbyte))
      else $error("mask not written");
   a_sel_guard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && wb_we_i && !wb_sel_i[0])
      |=> $stable(st_q.mode) && $stable(st_q.mask))
      else $error("write without byte select changed a register");
   a_write_no_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (req && wb_we_i)
      |=> wb_dat_o == eims_pkg::UNMAPPED_DATA)
      else $error("read data on a write");
endmodule
`default_nettype wire

// file: bench/eims_host.sv
// eims_host: host side that watches the active-low interrupt line.
// assumes irq_n_i is a registered level on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none
module eims_host (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic irq_n_i,
   output int falls_o
);
   logic prev_q;
   // counting falls rather than levels catches a line that never releases
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prev_q <= 1'b1;
         falls_o <= 0;
      end else begin
         prev_q <= irq_n_i;
         if (prev_q && !irq_n_i) begin
            falls_o <= falls_o + 1;
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/tb.sv
// tb: random and corner tests of eims_top over classic wishbone.
// assumes eims_host as the interrupt watcher; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [13:0] adr = 14'h0000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dw = 32'h0000_0000, dr, wb_dat_o;
   logic [11:0] ev = 12'h000;
   logic [7:0] v, vm[3];
   logic wb_ack_o, irq_n, irq;
   logic [3:0] wsel = 4'h1;
   int fail_count = 0, compares = 0, seen, r, i;
   int rg[12] = '{1, 1, 2, 3, 2, 3, 2, 3, 2, 3, 2, 2};
   int bt[12] = '{0, 2, 7, 7, 5, 5, 3, 3, 2, 2, 1, 0};
   always #5 clk_sys_i = ~clk_sys_i;
   eims_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pattern_check_error_ch0_i(ev[0]),
      .pattern_check_error_ch1_i(ev[1]), .power_detect_error_ch0_i(ev[2]),
      .power_detect_error_ch1_i(ev[3]), .blanking_finished_ch0_i(ev[4]),
      .blanking_finished_ch1_i(ev[5]), .alignment_locked_ch0_i(ev[6]),
      .alignment_locked_ch1_i(ev[7]), .alignment_rotated_ch0_i(ev[8]),
      .alignment_rotated_ch1_i(ev[9]), .outside_window_ch0_i(ev[10]),
      .alignment_tripped_ch0_i(ev[11]), .irq_n_o(irq_n), .irq_o(irq));
   eims_host host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .irq_n_i(irq_n), .falls_o(seen));
   task finish_test;
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // waits on ack at rising edges with a bound; read data taken at the ack edge
   task bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= wsel;
      dw <= {24'h00_0000, d};
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         $display("BAD wb_ack_o exp 1 got %b", wb_ack_o);
         finish_test;
      end else begin
         dr = wb_dat_o;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
      end
   endtask
   function automatic logic [31:0] st(input int rr, input logic [11:0] e);
      st = 32'h0000_0000;
      for (int k = 0; k < 12; k++) if (rg[k] == rr) st[bt[k]] = e[k];
   endfunction
   function automatic logic [11:0] ix(input logic [11:0] base, input int rr);
      ix = base + 12'(rr - 1);
   endfunction
   initial begin
      repeat (50000) @(posedge clk_sys_i);
      fail_count++;
      finish_test;
   end
   initial begin
      void'($urandom(27566));
      vm = '{eims_pkg::MODE1_VALID, eims_pkg::MODE2_VALID, eims_pkg::MODE3_VALID};
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (r = 1; r <= 3; r++) begin
         bus(1'b0, ix(eims_pkg::IDX_MODE1, r), 8'h00);
         chk("mode reset", 32'h0000_0000, dr);
         bus(1'b0, ix(eims_pkg::IDX_MASK1, r), 8'h00);
         chk("mask reset", 32'h0000_00FF, dr);
         v = 8'($urandom);
         bus(1'b1, ix(eims_pkg::IDX_MODE1, r), v);
         bus(1'b0, ix(eims_pkg::IDX_MODE1, r), 8'h00);
         chk("mode rw", {24'h00_0000, v & vm[r-1]}, dr);
         bus(1'b1, ix(eims_pkg::IDX_MODE1, r), 8'h00);
         v = 8'($urandom);
         bus(1'b1, ix(eims_pkg::IDX_MASK1, r), v);
         bus(1'b0, ix(eims_pkg::IDX_MASK1, r), 8'h00);
         chk("mask rw", {24'h00_0000, v}, dr);
         bus(1'b1, ix(eims_pkg::IDX_MASK1, r), eims_pkg::MASK_RESET);
      end
      wsel = 4'h0;
      bus(1'b1, eims_pkg::IDX_MODE1, eims_pkg::MODE1_VALID);
      wsel = 4'h1;
      bus(1'b0, eims_pkg::IDX_MODE1, 8'h00);
      chk("sel guard", 32'h0000_0000, dr);
      bus(1'b0, 12'h3FF, 8'h00);
      chk("unmapped", eims_pkg::UNMAPPED_DATA, dr);
      repeat (4) begin
         ev <= 12'($urandom);
         repeat (6) @(posedge clk_sys_i);
         for (r = 1; r <= 3; r++) begin
            bus(1'b0, ix(eims_pkg::IDX_STAT1, r), 8'h00);
            chk("live status", st(r, ev), dr);
         end
         chk("irq_n live", 32'h0000_0001, {31'h0, irq_n});
      end
      ev <= 12'h000;
      for (i = 0; i < 12; i++) begin
         v = 8'(1 << bt[i]);
         bus(1'b1, ix(eims_pkg::IDX_MODE1, rg[i]), v);
         repeat (6) @(posedge clk_sys_i);
         ev <= 12'(1 << i);
         repeat (6) @(posedge clk_sys_i);
         ev <= 12'h000;
         repeat (6) @(posedge clk_sys_i);
         chk("irq_n latched", 32'h0000_0000, {31'h0, irq_n});
         bus(1'b0, ix(eims_pkg::IDX_STAT1, rg[i]), 8'h00);
         chk("latched status", {24'h00_0000, v}, dr);
         chk("irq latched", 32'h0000_0001, {31'h0, irq});
         bus(1'b1, ix(eims_pkg::IDX_MASK1, rg[i]), 8'h00);
         repeat (3) @(posedge clk_sys_i);
         chk("irq masked", 32'h0000_0000, {31'h0, irq});
         chk("irq_n masked", 32'h0000_0000, {31'h0, irq_n});
         bus(1'b1, ix(eims_pkg::IDX_MASK1, rg[i]), eims_pkg::MASK_RESET);
         bus(1'b1, ix(eims_pkg::IDX_STAT1, rg[i]), v);
         repeat (3) @(posedge clk_sys_i);
         chk("irq_n cleared", 32'h0000_0001, {31'h0, irq_n});
         chk("irq cleared", 32'h0000_0000, {31'h0, irq});
         bus(1'b1, ix(eims_pkg::IDX_MODE1, rg[i]), 8'h00);
      end
      chk("irq falls", 32'h0000_000C, 32'(seen));
      bus(1'b1, eims_pkg::IDX_MODE2, 8'h80);
      ev <= 12'h004;
      repeat (6) @(posedge clk_sys_i);
      chk("irq_n pre reset", 32'h0000_0000, {31'h0, irq_n});
      rst_i <= 1'b1;
      ev <= 12'h000;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk("irq_n reset", 32'h0000_0001, {31'h0, irq_n});
      bus(1'b0, eims_pkg::IDX_MODE2, 8'h00);
      chk("mode after reset", 32'h0000_0000, dr);
      bus(1'b0, eims_pkg::IDX_MASK2, 8'h00);
      chk("mask after reset", 32'h0000_00FF, dr);
      finish_test;
   end
endmodule
`default_nettype wire
